// File: lmr_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the load model tracker
// Assumes: 32-bit register words on a plain strobe port, byte addresses
// Notes: included by bare name, definitions only
`ifndef LMR_CONSTS_SVH
`define LMR_CONSTS_SVH

// register byte offsets
`define LMR_REG_CFG 8'h00
`define LMR_REG_DSG_THR 8'h04
`define LMR_REG_CHG_THR 8'h08
`define LMR_REG_QUIT_CUR 8'h0C
`define LMR_REG_DSG_RELAX 8'h10
`define LMR_REG_CHG_RELAX 8'h14
`define LMR_REG_QUIT_RELAX 8'h18
`define LMR_REG_RES_CHG 8'h1C
`define LMR_REG_RES_EN 8'h20
`define LMR_REG_DESIGN_EN 8'h24
`define LMR_REG_USER_RATE 8'h28
`define LMR_REG_HOST_RATE 8'h2C
`define LMR_REG_STATUS 8'h30
`define LMR_REG_LEARNED 8'h34
`define LMR_REG_QMAX0 8'h38
`define LMR_REG_QMAX1 8'h3C
`define LMR_REG_LAST_I 8'h40
`define LMR_REG_LAST_P 8'h44
`define LMR_REG_LOAD_RATE 8'h48

// field positions
`define LMR_CFG_MODE_BIT 0
`define LMR_CFG_SEL_LSB 4
`define LMR_ST_DSG_BIT 0
`define LMR_ST_CHG_BIT 1
`define LMR_ST_RELAX_BIT 2
`define LMR_ST_OCV_BIT 3
`define LMR_ST_QOK_BIT 4
`define LMR_LEARN_BIT 0

// power-model selector codes
`define LMR_SEL_PREV_AVG 3'h0
`define LMR_SEL_CUR_AVG 3'h1
`define LMR_SEL_AVG_IV 3'h2
`define LMR_SEL_LPF_IV 3'h3
`define LMR_SEL_DESIGN 3'h4
`define LMR_SEL_HOST 3'h5
`define LMR_SEL_USER 3'h6

// reset values
`define LMR_RST_MODE 1'b0
`define LMR_RST_SEL 3'h0
`define LMR_RST_DSG_THR 16'h0064
`define LMR_RST_CHG_THR 16'h0064
`define LMR_RST_QUIT_CUR 16'h0032
`define LMR_RST_DSG_RELAX 16'h003C
`define LMR_RST_CHG_RELAX 16'h003C
`define LMR_RST_QUIT_RELAX 16'h0001
`define LMR_RST_RESERVE 16'h0000
`define LMR_RST_DESIGN_EN 16'h0000
`define LMR_RST_RATE 16'h0000

// timing
`define LMR_CLK_NS 5
`define LMR_SEC_NS 1000000000
`define LMR_OCV_WAIT_S 300
`define LMR_LPF_TAU_S 14
`define LMR_DVDT_MAX_UVS 4
`define LMR_LPF_FRAC 8

// unit scaling: mA*mV = uW, 10 mW = 10000 uW; energy/5 h in 10 mW units
`define LMR_UW_PER_10MW 10000
`define LMR_DESIGN_DIV 50

`endif

// File: lmr_pkg.sv
// Purpose: types of the load model tracker
// Assumes: constants come from lmr_consts.svh
// Notes: nothing is imported, users write lmr_pkg::name
package lmr_pkg;

  typedef enum logic [1:0] {
    LMR_FLOW = 2'b00,
    LMR_RELAX = 2'b01
  } lmr_mode_e;

endpackage

// File: lmr_tracker.sv
// Purpose: power load model selection, relaxation tracking and discharge-cycle logging
// Assumes: meas_valid marks a fresh current/voltage sample; currents signed mA, discharge negative
// Notes: load_rate is in 10 mW units and only valid in constant-power mode
// Assumes: avg_current_reading is already averaged upstream; this block filters it for selector 3 and uses it raw for relax timing and selector 2
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "lmr_consts.svh"

module lmr_tracker #(
  parameter int unsigned CYC_PER_SEC = `LMR_SEC_NS / `LMR_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurements
  input wire logic meas_valid,
  input wire logic signed [15:0] inst_current,
  input wire logic [15:0] cell_voltage,
  input wire logic signed [15:0] avg_current_reading,
  input wire logic [15:0] volt_slope_uvs,
  input wire logic [15:0] remaining_charge_reading,
  input wire logic [15:0] remaining_energy_reading,
  // capacity learning
  input wire logic qmax_req,
  input wire logic qmax_profile,
  input wire logic [15:0] qmax_value,
  // results
  output logic [15:0] load_rate,
  output logic load_rate_valid,
  output logic dsg_active,
  output logic chg_active,
  output logic relax_active,
  output logic ocv_enable,
  output logic qmax_ok,
  output logic [1:0] learned,
  output logic reserve_charge_on,
  output logic reserve_energy_on,
  output logic [15:0] reserve_charge_left,
  output logic [15:0] reserve_energy_left
);

  typedef struct packed {
    logic load_mode;
    logic [2:0] sel;
    logic [15:0] dsg_thr;
    logic [15:0] chg_thr;
    logic [15:0] quit_cur;
    logic [15:0] dsg_relax_s;
    logic [15:0] chg_relax_s;
    logic [15:0] quit_relax_s;
    logic [15:0] reserve_charge;
    logic [15:0] reserve_energy;
    logic [15:0] design_en;
    logic [15:0] user_rate;
    logic [15:0] host_rate;
    logic [1:0] learned;
    logic [15:0] qmax0;
    logic [15:0] qmax1;
    logic [15:0] last_i;
    logic [15:0] last_p;
    lmr_pkg::lmr_mode_e mode;
    logic last_chg;
    logic dsg;
    logic chg;
    logic [15:0] enter_t;
    logic [15:0] exit_t;
    logic [15:0] relax_t;
    logic [31:0] tick_cnt;
    logic signed [23:0] filt;
    logic [39:0] sum_i;
    logic [55:0] sum_p;
    logic [23:0] n;
    logic [15:0] rate;
    logic [31:0] rdata;
  } lmr_state_s;

  lmr_state_s s_q;
  lmr_state_s s_d;

  // magnitude of a signed current, 0x8000 stays representable as unsigned
  function automatic logic [15:0] mag16(input logic signed [15:0] x);
    mag16 = x[15] ? 16'(-x) : 16'(x);
  endfunction

  // sum over count, zero when nothing was summed; shared by both logs and selector 1
  function automatic logic [31:0] avg_of(input logic [55:0] sum, input logic [23:0] cnt);
    logic [55:0] q;
    q = 56'h0;
    if (cnt != 24'h00_0000) begin
      q = sum / {32'h0000_0000, cnt};
    end
    avg_of = q[31:0];
  endfunction

  // uW to 10 mW units, saturating at 16 bits
  function automatic logic [15:0] to_10mw(input logic [31:0] uw);
    logic [31:0] v;
    v = uw / 32'(`LMR_UW_PER_10MW);
    to_10mw = (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction

  // wait and slope limits sized to the relax timer and the slope port
  localparam logic [15:0] OCV_WAIT_S = 16'(`LMR_OCV_WAIT_S);
  localparam logic [15:0] DVDT_MAX = 16'(`LMR_DVDT_MAX_UVS);

  logic tick;
  logic [15:0] avg_mag;
  logic [15:0] inst_mag;
  logic [31:0] inst_pw;
  logic [15:0] filt_mag;
  logic [15:0] need_t;
  logic quiet;
  logic dsg_now;
  logic chg_now;
  logic gate;
  logic signed [24:0] filt_err;
  logic [31:0] cur_avg_p;
  logic [31:0] prev_avg_i;
  logic [31:0] prev_avg_p;

  // one-second time base; the filter and all relax timers count whole seconds
  // the cycle count per second is a parameter so simulation can shorten it
  assign tick = (s_q.tick_cnt == CYC_PER_SEC - 1);

  // combinational helpers read only registered state and the present sample
  assign avg_mag = mag16(avg_current_reading);
  assign inst_mag = mag16(inst_current);
  assign inst_pw = 32'(inst_mag) * 32'(cell_voltage);
  assign filt_mag = mag16(16'(s_q.filt >>> `LMR_LPF_FRAC));
  assign dsg_now = inst_current[15] && (inst_mag > s_q.dsg_thr);
  assign chg_now = !inst_current[15] && (inst_mag > s_q.chg_thr);
  assign quiet = avg_mag < s_q.quit_cur;
  assign need_t = s_q.last_chg ? s_q.chg_relax_s : s_q.dsg_relax_s;
  assign filt_err = 25'(signed'({avg_current_reading, 8'h00})) - 25'(s_q.filt);
  assign cur_avg_p = avg_of(s_q.sum_p, s_q.n);
  assign prev_avg_i = avg_of({16'h0000, s_q.sum_i}, s_q.n);
  assign prev_avg_p = cur_avg_p;
  // updates need settled relaxation plus a flat voltage slope
  assign gate = (s_q.mode == lmr_pkg::LMR_RELAX) && (s_q.relax_t >= OCV_WAIT_S)
              && (volt_slope_uvs < DVDT_MAX);

  // next state
  always_comb begin
    s_d = s_q;
    s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

    // register writes
    // read-only offsets fall to the default branch, so software cannot forge the logs
    if (reg_wr) begin
      case (reg_addr)
        `LMR_REG_CFG: begin
          s_d.load_mode = reg_wdata[`LMR_CFG_MODE_BIT];
          s_d.sel = reg_wdata[`LMR_CFG_SEL_LSB +: 3];
        end
        `LMR_REG_DSG_THR: s_d.dsg_thr = reg_wdata[15:0];
        `LMR_REG_CHG_THR: s_d.chg_thr = reg_wdata[15:0];
        `LMR_REG_QUIT_CUR: s_d.quit_cur = reg_wdata[15:0];
        `LMR_REG_DSG_RELAX: s_d.dsg_relax_s = reg_wdata[15:0];
        `LMR_REG_CHG_RELAX: s_d.chg_relax_s = reg_wdata[15:0];
        `LMR_REG_QUIT_RELAX: s_d.quit_relax_s = reg_wdata[15:0];
        `LMR_REG_RES_CHG: s_d.reserve_charge = reg_wdata[15:0];
        `LMR_REG_RES_EN: s_d.reserve_energy = reg_wdata[15:0];
        `LMR_REG_DESIGN_EN: s_d.design_en = reg_wdata[15:0];
        `LMR_REG_USER_RATE: s_d.user_rate = reg_wdata[15:0];
        `LMR_REG_HOST_RATE: s_d.host_rate = reg_wdata[15:0];
        `LMR_REG_LEARNED: s_d.learned = reg_wdata[1:0]; // golden-image override
        default: begin
        end
      endcase
    end

    // low-pass of the average current, one step per second, tau in seconds
    // truncation toward zero keeps the filter from overshooting its target;
    // the price is a residue below one step, well under one mA after the shift
    if (tick) begin
      s_d.filt = s_q.filt + 24'(filt_err / signed'(25'(`LMR_LPF_TAU_S)));
    end

    // flow classification and discharge-cycle logging on each sample
    // samples between both thresholds keep the last flow direction for relax timing
    if (meas_valid) begin
      s_d.dsg = dsg_now;
      s_d.chg = chg_now;
      if (dsg_now) begin
        s_d.last_chg = 1'b0;
        s_d.sum_i = s_q.sum_i + 40'(inst_mag);
        s_d.sum_p = s_q.sum_p + 56'(inst_pw);
        s_d.n = s_q.n + 24'h00_0001;
      end else begin
        if (chg_now) begin
          s_d.last_chg = 1'b1;
        end
        // a discharge cycle ends with its first non-discharge sample
        if (s_q.n != 24'h00_0000) begin
          s_d.last_i = (prev_avg_i > 32'h0000_FFFF) ? 16'hFFFF : prev_avg_i[15:0];
          s_d.last_p = to_10mw(prev_avg_p);
          s_d.sum_i = 40'h00_0000_0000;
          s_d.sum_p = 56'h00_0000_0000_0000;
          s_d.n = 24'h00_0000;
        end
      end
    end

    // relaxation tracking, timers in seconds
    // a timer only advances on the tick, so a break anywhere within a second
    // still restarts it; entry and exit timers never run at the same time
    case (s_q.mode)
      lmr_pkg::LMR_FLOW: begin
        s_d.relax_t = 16'h0000;
        s_d.exit_t = 16'h0000;
        if (!quiet) begin
          s_d.enter_t = 16'h0000;
        end else if (tick) begin
          if (s_q.enter_t + 16'h0001 >= need_t) begin
            s_d.mode = lmr_pkg::LMR_RELAX;
            s_d.enter_t = 16'h0000;
          end else begin
            s_d.enter_t = s_q.enter_t + 16'h0001;
          end
        end
      end
      lmr_pkg::LMR_RELAX: begin
        s_d.enter_t = 16'h0000;
        if (tick && s_q.relax_t != 16'hFFFF) begin
          s_d.relax_t = s_q.relax_t + 16'h0001;
        end
        if (quiet) begin
          s_d.exit_t = 16'h0000;
        end else if (tick) begin
          if (s_q.exit_t + 16'h0001 >= s_q.quit_relax_s) begin
            s_d.mode = lmr_pkg::LMR_FLOW;
            s_d.exit_t = 16'h0000;
          end else begin
            s_d.exit_t = s_q.exit_t + 16'h0001;
          end
        end
      end
      default: begin
        s_d.mode = lmr_pkg::LMR_FLOW;
      end
    endcase

    // capacity learning, applied after the register write so the set wins
    if (qmax_req && gate) begin
      if (qmax_profile) begin
        s_d.qmax1 = qmax_value;
      end else begin
        s_d.qmax0 = qmax_value;
      end
      s_d.learned[qmax_profile] = 1'b1;
    end

    // power-model rate; constant-current mode leaves the rate at zero
    // the rate is registered, so a selector change shows one cycle later
    s_d.rate = 16'h0000;
    if (s_q.load_mode) begin
      case (s_q.sel)
        `LMR_SEL_PREV_AVG: s_d.rate = s_q.last_p;
        `LMR_SEL_CUR_AVG: s_d.rate = to_10mw(cur_avg_p);
        `LMR_SEL_AVG_IV: s_d.rate = to_10mw(32'(avg_mag) * 32'(cell_voltage));
        `LMR_SEL_LPF_IV: s_d.rate = to_10mw(32'(filt_mag) * 32'(cell_voltage));
        `LMR_SEL_DESIGN: s_d.rate = 16'(s_q.design_en / 16'(`LMR_DESIGN_DIV));
        `LMR_SEL_HOST: s_d.rate = s_q.host_rate;
        `LMR_SEL_USER: s_d.rate = s_q.user_rate;
        default: s_d.rate = 16'h0000;
      endcase
    end

    // read data stands in the cycle after the strobe only
    // status bits are taken at the read strobe, not latched in between
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `LMR_REG_CFG: begin
          s_d.rdata[`LMR_CFG_MODE_BIT] = s_q.load_mode;
          s_d.rdata[`LMR_CFG_SEL_LSB +: 3] = s_q.sel;
        end
        `LMR_REG_DSG_THR: s_d.rdata = {16'h0000, s_q.dsg_thr};
        `LMR_REG_CHG_THR: s_d.rdata = {16'h0000, s_q.chg_thr};
        `LMR_REG_QUIT_CUR: s_d.rdata = {16'h0000, s_q.quit_cur};
        `LMR_REG_DSG_RELAX: s_d.rdata = {16'h0000, s_q.dsg_relax_s};
        `LMR_REG_CHG_RELAX: s_d.rdata = {16'h0000, s_q.chg_relax_s};
        `LMR_REG_QUIT_RELAX: s_d.rdata = {16'h0000, s_q.quit_relax_s};
        `LMR_REG_RES_CHG: s_d.rdata = {16'h0000, s_q.reserve_charge};
        `LMR_REG_RES_EN: s_d.rdata = {16'h0000, s_q.reserve_energy};
        `LMR_REG_DESIGN_EN: s_d.rdata = {16'h0000, s_q.design_en};
        `LMR_REG_USER_RATE: s_d.rdata = {16'h0000, s_q.user_rate};
        `LMR_REG_HOST_RATE: s_d.rdata = {16'h0000, s_q.host_rate};
        `LMR_REG_STATUS: begin
          s_d.rdata[`LMR_ST_DSG_BIT] = s_q.dsg;
          s_d.rdata[`LMR_ST_CHG_BIT] = s_q.chg;
          s_d.rdata[`LMR_ST_RELAX_BIT] = (s_q.mode == lmr_pkg::LMR_RELAX);
          s_d.rdata[`LMR_ST_OCV_BIT] = (s_q.mode == lmr_pkg::LMR_RELAX)
                                      && (s_q.relax_t >= OCV_WAIT_S);
          s_d.rdata[`LMR_ST_QOK_BIT] = gate;
        end
        `LMR_REG_LEARNED: s_d.rdata = {30'h0000_0000, s_q.learned};
        `LMR_REG_QMAX0: s_d.rdata = {16'h0000, s_q.qmax0};
        `LMR_REG_QMAX1: s_d.rdata = {16'h0000, s_q.qmax1};
        `LMR_REG_LAST_I: s_d.rdata = {16'h0000, s_q.last_i};
        `LMR_REG_LAST_P: s_d.rdata = {16'h0000, s_q.last_p};
        `LMR_REG_LOAD_RATE: s_d.rdata = {16'h0000, s_q.rate};
        default: s_d.rdata = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // state register
  // synchronous reset; logs, learned bits and timers all clear with it
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.load_mode <= `LMR_RST_MODE;
      s_q.sel <= `LMR_RST_SEL;
      s_q.dsg_thr <= `LMR_RST_DSG_THR;
      s_q.chg_thr <= `LMR_RST_CHG_THR;
      s_q.quit_cur <= `LMR_RST_QUIT_CUR;
      s_q.dsg_relax_s <= `LMR_RST_DSG_RELAX;
      s_q.chg_relax_s <= `LMR_RST_CHG_RELAX;
      s_q.quit_relax_s <= `LMR_RST_QUIT_RELAX;
      s_q.reserve_charge <= `LMR_RST_RESERVE;
      s_q.reserve_energy <= `LMR_RST_RESERVE;
      s_q.design_en <= `LMR_RST_DESIGN_EN;
      s_q.user_rate <= `LMR_RST_RATE;
      s_q.host_rate <= `LMR_RST_RATE;
      s_q.mode <= lmr_pkg::LMR_FLOW;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; the reserves are reported raw because they are held at no-load rate
  // reserve flags follow the readings combinationally, sample them settled
  assign reg_rdata = s_q.rdata;
  assign load_rate = s_q.rate;
  assign load_rate_valid = s_q.load_mode;
  assign dsg_active = s_q.dsg;
  assign chg_active = s_q.chg;
  assign relax_active = (s_q.mode == lmr_pkg::LMR_RELAX);
  assign ocv_enable = relax_active && (s_q.relax_t >= OCV_WAIT_S);
  assign qmax_ok = gate;
  assign learned = s_q.learned;
  assign reserve_charge_on = (remaining_charge_reading == 16'h0000);
  assign reserve_energy_on = (remaining_energy_reading == 16'h0000);
  assign reserve_charge_left = s_q.reserve_charge;
  assign reserve_energy_left = s_q.reserve_energy;

endmodule

// File: lmr_tracker_properties.sv
// Purpose: port-level checks of the load model tracker
// Assumes: bound to lmr_tracker, single clock domain
// Notes: thresholds live in registers, so sign checks stand in for the level checks
`timescale 1ns/1ps
`include "lmr_consts.svh"
module lmr_tracker_props #(
  parameter int unsigned CYC_PER_SEC = 10
) (
  // clock, reset, register port
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // measurements and learning
  input wire logic meas_valid,
  input wire logic signed [15:0] inst_current,
  input wire logic [15:0] volt_slope_uvs,
  input wire logic [15:0] remaining_charge_reading,
  input wire logic [15:0] remaining_energy_reading,
  input wire logic qmax_req,
  input wire logic qmax_profile,
  // results
  input wire logic [15:0] load_rate,
  input wire logic load_rate_valid,
  input wire logic dsg_active,
  input wire logic chg_active,
  input wire logic relax_active,
  input wire logic ocv_enable,
  input wire logic qmax_ok,
  input wire logic [1:0] learned,
  input wire logic reserve_charge_on,
  input wire logic reserve_energy_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // configuration write and two idle cycles of a stopped rate
  sequence s_cfg_wr;
    reg_wr && reg_addr == `LMR_REG_CFG;
  endsequence
  sequence s_rate_off;
    !load_rate_valid ##1 !load_rate_valid;
  endsequence

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  a_mode_follows_cfg: assert property (s_cfg_wr |=> load_rate_valid == $past(reg_wdata[0]))
    else $error("load mode flag does not follow config write");
  a_rate_zero_off: assert property (s_rate_off |-> load_rate == 16'h0000)
    else $error("load rate nonzero outside power mode");
  a_dsg_needs_neg: assert property (meas_valid && !inst_current[15] |=> !dsg_active)
    else $error("discharge flagged on non-negative current");
  a_chg_needs_pos: assert property (meas_valid && (inst_current <= 0) |=> !chg_active)
    else $error("charge flagged on non-positive current");
  a_flags_hold: assert property (!meas_valid |=> $stable(dsg_active) && $stable(chg_active))
    else $error("flow flags moved without a sample");
  a_qmax_gate: assert property (qmax_ok |-> relax_active && ocv_enable && volt_slope_uvs < 16'd4)
    else $error("capacity update allowed outside relaxed low slope");
  a_learn_sets: assert property (qmax_req && qmax_ok |=> learned[$past(qmax_profile)])
    else $error("learned bit not set after capacity update");
  a_learn_refused: assert property (qmax_req && !qmax_ok && !reg_wr |=> $stable(learned))
    else $error("learned bits changed on refused update");
  a_reserve_flags: assert property (reserve_charge_on == (remaining_charge_reading == 16'h0000)
    && reserve_energy_on == (remaining_energy_reading == 16'h0000))
    else $error("reserve flag does not match zero reading");
  a_ocv_waits: assert property ($rose(relax_active) |-> !ocv_enable [*8])
    else $error("open-circuit readings enabled right at relax entry");
endmodule

bind lmr_tracker lmr_tracker_props #(.CYC_PER_SEC(CYC_PER_SEC)) i_props (.clk, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .meas_valid, .inst_current,
  .volt_slope_uvs, .remaining_charge_reading, .remaining_energy_reading, .qmax_req,
  .qmax_profile, .load_rate, .load_rate_valid, .dsg_active, .chg_active, .relax_active,
  .ocv_enable, .qmax_ok, .learned, .reserve_charge_on, .reserve_energy_on);

// File: lmr_cell.sv
// Purpose: behavioural cell seen through the sense resistor
// Assumes: bench sets the load current and terminal voltage
// Notes: averaged current simply trails the last sample, no real filtering
`timescale 1ns/1ps
module lmr_cell (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // load set by the bench
  input wire logic signed [15:0] load_ma,
  input wire logic [15:0] volt_mv,
  // measurements
  output logic meas_valid = 1'b0,
  output logic signed [15:0] inst_current = 16'sh0000,
  output logic [15:0] cell_voltage = 16'h0000,
  output logic signed [15:0] avg_current_reading = 16'sh0000
);
  logic [1:0] div_q = 2'h0;
  // one sample every fourth cycle, like a slow converter
  always @(posedge clk) begin
    if (srst) begin
      div_q <= 2'h0;
      meas_valid <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      meas_valid <= (div_q == 2'h3);
      if (div_q == 2'h3) begin
        inst_current <= load_ma;
        cell_voltage <= volt_mv;
      end
      avg_current_reading <= inst_current;
    end
  end
endmodule

// File: lmr_tracker_tb.sv
// Purpose: self-checking bench of the load model tracker
// Assumes: one second shortened to 10 cycles
// Notes: read results go through a queue, flags are checked at the ports
`timescale 1ns/1ps
`include "lmr_consts.svh"
module lmr_tracker_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic meas_valid;
  logic signed [15:0] inst_current, avg_current_reading;
  logic [15:0] cell_voltage, load_rate, reserve_charge_left, reserve_energy_left;
  logic signed [15:0] load_ma = 16'sh0000;
  logic [15:0] volt_mv = 16'h0FA0;
  logic [15:0] slope = 16'h0000;
  logic [15:0] rem_chg = 16'h0005;
  logic [15:0] rem_en = 16'h0005;
  logic qmax_req = 1'b0;
  logic qmax_profile = 1'b0;
  logic [15:0] qmax_value = 16'h0000;
  logic load_rate_valid, dsg_active, chg_active, relax_active, ocv_enable, qmax_ok;
  logic reserve_charge_on, reserve_energy_on, rd_d = 1'b0;
  logic [1:0] learned;
  logic [31:0] seed = 32'h0000_82db;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  logic [15:0] mag, pw, rv;
  logic signed [15:0] cur_t[4] = '{-16'sd100, -16'sd101, 16'sd100, 16'sd101};

  always #2.5 clk = ~clk;

  lmr_cell i_cell (.clk(clk), .srst(srst), .load_ma(load_ma), .volt_mv(volt_mv),
    .meas_valid(meas_valid), .inst_current(inst_current), .cell_voltage(cell_voltage),
    .avg_current_reading(avg_current_reading));

  lmr_tracker #(.CYC_PER_SEC(10)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_valid(meas_valid), .inst_current(inst_current), .cell_voltage(cell_voltage),
    .avg_current_reading(avg_current_reading), .volt_slope_uvs(slope),
    .remaining_charge_reading(rem_chg), .remaining_energy_reading(rem_en),
    .qmax_req(qmax_req), .qmax_profile(qmax_profile), .qmax_value(qmax_value),
    .load_rate(load_rate), .load_rate_valid(load_rate_valid), .dsg_active(dsg_active),
    .chg_active(chg_active), .relax_active(relax_active), .ocv_enable(ocv_enable),
    .qmax_ok(qmax_ok), .learned(learned), .reserve_charge_on(reserve_charge_on),
    .reserve_energy_on(reserve_energy_on), .reserve_charge_left(reserve_charge_left),
    .reserve_energy_left(reserve_energy_left));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // the answer is noted here and compared by the watcher one cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // select a power model, let the registered rate settle, read it back
  task automatic sel(input logic [2:0] code, input logic mode, input logic [15:0] exp);
    wr(`LMR_REG_CFG, {25'h0, code, 3'h0, mode});
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk32({15'h0000, load_rate_valid, load_rate}, {15'h0000, mode, exp});
    rd(`LMR_REG_LOAD_RATE, {16'h0000, exp});
  endtask

  task automatic qreq(input logic p, input logic [15:0] v);
    @(posedge clk);
    qmax_req <= 1'b1;
    qmax_profile <= p;
    qmax_value <= v;
    @(posedge clk);
    qmax_req <= 1'b0;
  endtask

  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      chk32(reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(`LMR_REG_CFG, 32'h0000_0000);
    rd(`LMR_REG_DSG_THR, 32'h0000_0064);
    rd(`LMR_REG_CHG_THR, 32'h0000_0064);
    rd(`LMR_REG_QUIT_RELAX, 32'h0000_0001);
    rd(8'h4C, 32'h0000_0000);
    wr(`LMR_REG_LAST_I, 32'h0000_1234);
    rd(`LMR_REG_LAST_I, 32'h0000_0000);
    // short relax times; quit current stays above the idle draw of the cell
    wr(`LMR_REG_DSG_RELAX, 32'h0000_0002);
    wr(`LMR_REG_CHG_RELAX, 32'h0000_0002);
    wr(`LMR_REG_QUIT_CUR, 32'h0000_0032);
    load_ma <= 16'sh0000;
    for (int i = 0; i < 200 && relax_active !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk32({31'h0, relax_active}, 32'h1);
    chk32({31'h0, ocv_enable}, 32'h0);
    for (int i = 0; i < 4000 && ocv_enable !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk32({31'h0, ocv_enable}, 32'h1);
    @(posedge clk);
    slope <= 16'h0004;
    qreq(1'b0, 16'h0AAA);
    rd(`LMR_REG_LEARNED, 32'h0000_0000);
    seed = lfsr(seed);
    rv = seed[15:0];
    slope <= 16'h0003;
    qreq(1'b1, rv);
    rd(`LMR_REG_LEARNED, 32'h0000_0002);
    rd(`LMR_REG_QMAX1, {16'h0000, rv});
    wr(`LMR_REG_LEARNED, 32'h0000_0001);
    rd(`LMR_REG_LEARNED, 32'h0000_0001);
    // discharge at a random level, leaving relaxation on the way
    seed = lfsr(seed);
    mag = 16'(seed[9:0] % 10'd900) + 16'd101;
    pw = 16'(32'(mag) * 32'd4000 / 32'd10000);
    load_ma <= -$signed(mag);
    for (int i = 0; i < 100 && relax_active !== 1'b0; i++) @(posedge clk);
    @(negedge clk);
    chk32({31'h0, relax_active}, 32'h0);
    repeat (20) @(posedge clk);
    sel(`LMR_SEL_CUR_AVG, 1'b1, pw);
    sel(`LMR_SEL_AVG_IV, 1'b1, pw);
    // the filter needs many time constants to settle on the steady current
    repeat (2500) @(posedge clk);
    sel(`LMR_SEL_LPF_IV, 1'b1, pw);
    load_ma <= 16'sh0000;
    repeat (20) @(posedge clk);
    rd(`LMR_REG_LAST_I, {16'h0000, mag});
    rd(`LMR_REG_LAST_P, {16'h0000, pw});
    sel(`LMR_SEL_PREV_AVG, 1'b1, pw);
    wr(`LMR_REG_DESIGN_EN, 32'h0000_1388);
    sel(`LMR_SEL_DESIGN, 1'b1, 16'h0064);
    seed = lfsr(seed);
    wr(`LMR_REG_HOST_RATE, {16'h0000, seed[15:0]});
    sel(`LMR_SEL_HOST, 1'b1, seed[15:0]);
    seed = lfsr(seed);
    wr(`LMR_REG_USER_RATE, {16'h0000, seed[15:0]});
    sel(`LMR_SEL_USER, 1'b1, seed[15:0]);
    sel(`LMR_SEL_USER, 1'b0, 16'h0000);
    // both sides of each flow threshold
    foreach (cur_t[k]) begin
      @(posedge clk);
      load_ma <= cur_t[k];
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk32({31'h0, dsg_active}, {31'h0, k == 1});
      chk32({31'h0, chg_active}, {31'h0, k == 3});
    end
    seed = lfsr(seed);
    wr(`LMR_REG_RES_CHG, {16'h0000, seed[15:0]});
    wr(`LMR_REG_RES_EN, {16'h0000, ~seed[15:0]});
    rem_chg <= 16'h0000;
    rem_en <= 16'h0000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk32({reserve_charge_left, 14'h0, reserve_charge_on, reserve_energy_on},
      {seed[15:0], 16'h0003});
    rd(`LMR_REG_RES_CHG, {16'h0000, seed[15:0]});
    rd(`LMR_REG_RES_EN, {16'h0000, ~seed[15:0]});
    @(negedge clk);
    chk32({16'h0000, reserve_energy_left}, {16'h0000, ~seed[15:0]});
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule
